// ===== rtl/bcl_pkg.sv
// Constants and types shared by the boot configuration latch block
package bcl_pkg;

  // Latch array geometry
  localparam int          NVL_BYTES      = 4;
  localparam int          BYTE_W         = 8;
  localparam int          PORT_COUNT     = 9;
  localparam int          PORT_MODES_W   = 18;

  // Register indices; byte address is four times the index
  localparam logic [2:0]  IDX_PORT_LOW   = 3'h0;
  localparam logic [2:0]  IDX_PORT_HIGH  = 3'h1;
  localparam logic [2:0]  IDX_RST_DBG    = 3'h2;
  localparam logic [2:0]  IDX_BOOT_ECC   = 3'h3;
  localparam logic [2:0]  IDX_APPLIED    = 3'h4;
  localparam logic [2:0]  IDX_ECC_STAT   = 3'h5;
  localparam int          ADDR_IDX_LSB   = 2;
  localparam int          ADDR_IDX_W     = 3;

  // Factory defaults of the four latch bytes and writable mask of latch byte 2
  localparam logic [7:0]  DEF_PORT_LOW   = 8'h00;
  localparam logic [7:0]  DEF_PORT_HIGH  = 8'h00;
  localparam logic [7:0]  DEF_RST_DBG    = 8'h40;
  localparam logic [7:0]  DEF_BOOT_ECC   = 8'h0a;
  localparam logic [7:0]  MASK_RST_DBG   = 8'hc3;

  // Field positions
  localparam int          B2_PRT15_LSB   = 0;
  localparam int          B2_DBG_BIT     = 6;
  localparam int          B2_XRES_BIT    = 7;
  localparam int          B3_SPEED_BIT   = 0;
  localparam int          B3_DPS_LSB     = 1;
  localparam int          B3_ECC_BIT     = 3;
  localparam int          B3_PHS_LSB     = 4;
  localparam int          STAT_SGL_BIT   = 0;
  localparam int          STAT_DBL_BIT   = 1;

  // Port reset drive modes
  localparam logic [1:0]  DRV_HIZ_ANALOG = 2'h0;
  localparam logic [1:0]  DRV_HIZ_DIGITAL = 2'h1;
  localparam logic [1:0]  DRV_PULL_UP    = 2'h2;
  localparam logic [1:0]  DRV_PULL_DOWN  = 2'h3;

  // Debug port selections
  localparam logic [1:0]  DPS_JTAG5      = 2'h0;
  localparam logic [1:0]  DPS_JTAG4      = 2'h1;
  localparam logic [1:0]  DPS_SWD        = 2'h2;
  localparam logic [1:0]  DPS_OFF        = 2'h3;

  // Boot oscillator speeds in MHz
  localparam logic [7:0]  BOOT_SLOW_MHZ  = 8'h0c;
  localparam logic [7:0]  BOOT_FAST_MHZ  = 8'h30;

  // Bus and flash word constants
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam int          FW_DATA_W      = 64;
  localparam int          ECC_W          = 8;
  localparam int          CHK_W          = 7;
  localparam int          CW_LAST_POS    = 71;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } bcl_phase_type;

endpackage : bcl_pkg

// ===== rtl/bcl_boot_config.sv
// Boot configuration latch array with AHB-Lite access and flash ECC check
//
// What this block does
// - Four latch bytes configure device at reset
// - Two-bit reset drive mode per listed port
// - Modes: analog, digital, pull-up, pull-down
// - Select bit makes shared pin external reset
// - Debug access allowed only when bit set
// - Boot oscillator 12 or 48 MHz
// - Debug port: JTAG5, JTAG4, SWD, off
// - ECC bit on: extra flash holds codes
// - Four-bit digital clock phase delay field
// - Correct single, detect double per 8 bytes
`timescale 1ns/100ps
`default_nettype none

module bcl_boot_config (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_ce,
  input  wire logic                         i_por_reset,
  input  wire logic                         i_hsel,
  input  wire logic [31:0]                  i_haddr,
  input  wire logic [1:0]                   i_htrans,
  input  wire logic                         i_hwrite,
  input  wire logic [2:0]                   i_hsize,
  input  wire logic [31:0]                  i_hwdata,
  input  wire logic                         i_hready,
  output logic [31:0]                       o_hrdata,
  output logic                              o_hreadyout,
  output logic                              o_hresp,
  input  wire logic                         i_flash_valid,
  input  wire logic [bcl_pkg::FW_DATA_W-1:0] i_flash_data,
  input  wire logic [bcl_pkg::ECC_W-1:0]    i_flash_ecc,
  output logic                              o_flash_rvalid,
  output logic [bcl_pkg::FW_DATA_W-1:0]     o_flash_data,
  output logic                              o_ecc_single,
  output logic                              o_ecc_double,
  output logic                              o_port_hold_reset,
  output logic [bcl_pkg::PORT_MODES_W-1:0]  o_port_drive_mode,
  output logic                              o_ext_reset_pin_select,
  output logic                              o_debug_access_allow,
  output logic [1:0]                        o_debug_port_select,
  output logic                              o_debug_enable,
  output logic                              o_boot_osc_speed_select,
  output logic [7:0]                        o_boot_osc_mhz,
  output logic                              o_flash_ecc_use,
  output logic [3:0]                        o_digital_clk_phase_delay
);
  import bcl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]                latch_q [NVL_BYTES];
  logic [7:0]                latch_d [NVL_BYTES];
  logic                      wr_pend_q;
  logic [ADDR_IDX_W-1:0]     wr_idx_q;
  logic [31:0]               rdata_d;
  logic [ADDR_IDX_W-1:0]     rd_idx;
  logic                      ahb_go;
  bcl_phase_type             phase_q;
  logic [1:0]                stat_q;
  logic [1:0]                stat_d;
  logic [CHK_W-1:0]          syn;
  logic                      par_err;
  logic [FW_DATA_W-1:0]      flip;
  logic [31:0]               applied;
  logic [2*ECC_W-1:0]        unused_bits;

  ////////////////////////////////////////////////////////////////////////////
  // ECC helpers

  // Check bits: XOR of data bits by codeword position, powers of two skipped
  function automatic logic [CHK_W-1:0] ecc_check(input logic [FW_DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int               di;
    c  = '0;
    di = 0;
    for (int p = 1; p <= CW_LAST_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[di]) begin
          c = c ^ p[CHK_W-1:0];
        end
        di = di + 1;
      end
    end
    return c;
  endfunction : ecc_check

  // Data bit that a syndrome points to, as a one-hot flip mask
  function automatic logic [FW_DATA_W-1:0] ecc_flip(input logic [CHK_W-1:0] s);
    logic [FW_DATA_W-1:0] m;
    int                   di;
    m  = '0;
    di = 0;
    for (int p = 1; p <= CW_LAST_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p[CHK_W-1:0] == s) begin
          m[di] = 1'b1;
        end
        di = di + 1;
      end
    end
    return m;
  endfunction : ecc_flip

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  // Transfer taken when selected, bus ready and htrans NONSEQ or SEQ
  assign ahb_go = i_hsel && i_hready && i_htrans[1];
  assign rd_idx = i_haddr[ADDR_IDX_LSB +: ADDR_IDX_W];
  assign unused_bits = {i_haddr[31:24], i_hsize, i_haddr[1:0], i_haddr[23:21]};

  // Address phase capture for the write data phase
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_reset) begin
        wr_pend_q <= 1'b0;
        wr_idx_q  <= '0;
      end else begin
        wr_pend_q <= ahb_go && i_hwrite;
        wr_idx_q  <= rd_idx;
      end
    end
  end

  // Latch bytes after a pending data-phase write; reserved bits forced to zero
  always_comb begin
    for (int b = 0; b < NVL_BYTES; b++) begin
      latch_d[b] = latch_q[b];
    end
    if (wr_pend_q) begin
      case (wr_idx_q)
        IDX_PORT_LOW:  latch_d[0] = i_hwdata[7:0];
        IDX_PORT_HIGH: latch_d[1] = i_hwdata[7:0];
        IDX_RST_DBG:   latch_d[2] = i_hwdata[7:0] & MASK_RST_DBG;
        IDX_BOOT_ECC:  latch_d[3] = i_hwdata[7:0];
        default:       latch_d[0] = latch_q[0];
      endcase
    end
  end

  // Latch array keeps its contents across device reset; power-on loads defaults
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_por_reset) begin
        latch_q[0] <= DEF_PORT_LOW;
        latch_q[1] <= DEF_PORT_HIGH;
        latch_q[2] <= DEF_RST_DBG;
        latch_q[3] <= DEF_BOOT_ECC;
      end else begin
        for (int b = 0; b < NVL_BYTES; b++) begin
          latch_q[b] <= latch_d[b];
        end
      end
    end
  end

  // Applied configuration packed back in latch byte order
  assign applied = {
    o_digital_clk_phase_delay, o_flash_ecc_use, o_debug_port_select, o_boot_osc_speed_select,
    o_ext_reset_pin_select, o_debug_access_allow, 4'h0, o_port_drive_mode
  };

  // Read mux uses next-state latches so a write just ahead is seen
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (rd_idx)
      IDX_PORT_LOW:  rdata_d[7:0] = latch_d[0];
      IDX_PORT_HIGH: rdata_d[7:0] = latch_d[1];
      IDX_RST_DBG:   rdata_d[7:0] = latch_d[2];
      IDX_BOOT_ECC:  rdata_d[7:0] = latch_d[3];
      IDX_APPLIED:   rdata_d      = applied;
      IDX_ECC_STAT:  rdata_d[1:0] = stat_d;
      default:       rdata_d      = 32'h0000_0000;
    endcase
  end

  // Zero-wait answer: read data registered in the address phase
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_reset) begin
        o_hrdata    <= 32'h0000_0000;
        o_hreadyout <= 1'b1;
        o_hresp     <= HRESP_OKAY;
      end else begin
        o_hrdata    <= (ahb_go && !i_hwrite) ? rdata_d : 32'h0000_0000;
        o_hreadyout <= 1'b1;
        o_hresp     <= HRESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration apply

  // Track latches while reset is held, freeze at release
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_reset) begin
        phase_q                   <= ST_HOLD;
        o_port_hold_reset         <= 1'b1;
        o_port_drive_mode         <= {latch_q[2][B2_PRT15_LSB +: 2], latch_q[1], latch_q[0]};
        o_ext_reset_pin_select    <= latch_q[2][B2_XRES_BIT];
        o_debug_access_allow      <= latch_q[2][B2_DBG_BIT];
        o_debug_port_select       <= latch_q[3][B3_DPS_LSB +: 2];
        o_debug_enable            <= latch_q[2][B2_DBG_BIT] && (latch_q[3][B3_DPS_LSB +: 2] != DPS_OFF);
        o_boot_osc_speed_select   <= latch_q[3][B3_SPEED_BIT];
        o_boot_osc_mhz            <= latch_q[3][B3_SPEED_BIT] ? BOOT_FAST_MHZ : BOOT_SLOW_MHZ;
        o_flash_ecc_use           <= latch_q[3][B3_ECC_BIT];
        o_digital_clk_phase_delay <= latch_q[3][B3_PHS_LSB +: 4];
      end else begin
        phase_q           <= ST_RUN;
        o_port_hold_reset <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash ECC check

  // Syndrome, overall parity and correction mask
  assign syn     = ecc_check(i_flash_data) ^ i_flash_ecc[CHK_W-1:0];
  assign par_err = (^i_flash_data) ^ (^i_flash_ecc);
  assign flip    = ecc_flip(syn);

  // Registered decode; bypassed when ECC is not used
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_reset) begin
        o_flash_rvalid <= 1'b0;
        o_flash_data   <= '0;
        o_ecc_single   <= 1'b0;
        o_ecc_double   <= 1'b0;
      end else begin
        o_flash_rvalid <= i_flash_valid;
        if (i_flash_valid && o_flash_ecc_use) begin
          o_flash_data <= par_err ? (i_flash_data ^ flip) : i_flash_data;
          o_ecc_single <= par_err;
          o_ecc_double <= !par_err && (syn != '0);
        end else begin
          o_flash_data <= i_flash_valid ? i_flash_data : o_flash_data;
          o_ecc_single <= 1'b0;
          o_ecc_double <= 1'b0;
        end
      end
    end
  end

  // Sticky error flags; an error in the clearing cycle wins
  always_comb begin
    stat_d = stat_q;
    if (wr_pend_q && (wr_idx_q == IDX_ECC_STAT)) begin
      stat_d = stat_q & ~i_hwdata[1:0];
    end
    stat_d[STAT_SGL_BIT] = stat_d[STAT_SGL_BIT] | o_ecc_single;
    stat_d[STAT_DBL_BIT] = stat_d[STAT_DBL_BIT] | o_ecc_double;
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_reset) begin
        stat_q <= 2'h0;
      end else begin
        stat_q <= stat_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || i_por_reset);

  sequence release_s;
    i_reset && i_ce ##1 !i_reset && i_ce;
  endsequence

  sequence steady_s;
    !i_reset ##1 !i_reset;
  endsequence

  cfg_load_a: assert property (
    disable iff (i_por_reset) (i_reset && i_ce) |=> (o_port_drive_mode[7:0] == $past(latch_q[0])
      && o_digital_clk_phase_delay == $past(latch_q[3][B3_PHS_LSB +: 4])))
    else $error("latch byte not applied during reset");

  cfg_hold_a: assert property (
    disable iff (i_por_reset) steady_s |-> $stable(applied) && phase_q == ST_RUN)
    else $error("applied configuration changed outside reset");

  port_hold_a: assert property (
    disable iff (i_por_reset) release_s |-> o_port_hold_reset ##1 !o_port_hold_reset)
    else $error("port hold flag wrong around reset release");

  debug_gate_a: assert property (
    o_debug_enable == (o_debug_access_allow && o_debug_port_select != DPS_OFF))
    else $error("debug enable disagrees with allow and port select");

  boot_speed_a: assert property (
    o_boot_osc_mhz == (o_boot_osc_speed_select ? BOOT_FAST_MHZ : BOOT_SLOW_MHZ))
    else $error("boot oscillator speed mismatch");

  ecc_bypass_a: assert property (
    (i_ce && i_flash_valid && !o_flash_ecc_use) |=> o_flash_data == $past(i_flash_data)
      && !o_ecc_single && !o_ecc_double)
    else $error("flash word altered with ECC unused");

  ecc_clean_a: assert property (
    (i_ce && i_flash_valid && o_flash_ecc_use && syn == '0 && !par_err) |=>
      o_flash_data == $past(i_flash_data) && !o_ecc_single && !o_ecc_double)
    else $error("clean flash word flagged or changed");

  ecc_excl_a: assert property (
    !(o_ecc_single && o_ecc_double))
    else $error("single and double error both flagged");

  factory_def_a: assert property (
    disable iff (1'b0) (i_por_reset && i_ce) |=> latch_q[2] == DEF_RST_DBG
      && latch_q[3] == DEF_BOOT_ECC && latch_q[0] == DEF_PORT_LOW)
    else $error("factory defaults not loaded");

  bus_okay_a: assert property (
    o_hreadyout && o_hresp == HRESP_OKAY)
    else $error("slave not ready or not OKAY");

  reserved_a: assert property (
    (latch_q[2] & ~MASK_RST_DBG) == 8'h00)
    else $error("reserved latch bits set");

  stat_set_a: assert property (
    (i_ce && o_ecc_single) |=> stat_q[STAT_SGL_BIT])
    else $error("single error not recorded in status");

  cfg_freeze_a: assert property (
    (!i_reset && i_ce) |=> $stable(o_ext_reset_pin_select) && $stable(o_debug_port_select))
    else $error("configuration changed outside reset");

endmodule : bcl_boot_config

`default_nettype wire

// ===== test/bcl_boot_config_tb.sv
// Self-checking testbench for the boot configuration latch block
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module bcl_boot_config_tb;
  import bcl_pkg::*;

  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_por_reset = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'b0;
  logic [2:0]  i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic        i_flash_valid = 1'b0;
  logic [63:0] i_flash_data = 64'h0;
  logic [7:0]  i_flash_ecc = 8'h0;
  wire  [31:0] o_hrdata;
  wire         o_hreadyout, o_hresp, o_flash_rvalid, o_ecc_single, o_ecc_double;
  wire  [63:0] o_flash_data;
  wire         o_port_hold_reset, o_ext_reset_pin_select, o_debug_access_allow;
  wire  [17:0] o_port_drive_mode;
  wire  [1:0]  o_debug_port_select;
  wire         o_debug_enable, o_boot_osc_speed_select, o_flash_ecc_use;
  wire  [7:0]  o_boot_osc_mhz;
  wire  [3:0]  o_digital_clk_phase_delay;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [63:0] wd;
  logic [7:0]  we, b2, b3;
  logic [1:0]  kk;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and run limit
  always #25 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device under test; hready loops back from the only slave
  bcl_boot_config bcl_boot_config_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_por_reset(i_por_reset),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_flash_valid(i_flash_valid), .i_flash_data(i_flash_data), .i_flash_ecc(i_flash_ecc),
    .o_flash_rvalid(o_flash_rvalid), .o_flash_data(o_flash_data),
    .o_ecc_single(o_ecc_single), .o_ecc_double(o_ecc_double),
    .o_port_hold_reset(o_port_hold_reset), .o_port_drive_mode(o_port_drive_mode),
    .o_ext_reset_pin_select(o_ext_reset_pin_select),
    .o_debug_access_allow(o_debug_access_allow), .o_debug_port_select(o_debug_port_select),
    .o_debug_enable(o_debug_enable), .o_boot_osc_speed_select(o_boot_osc_speed_select),
    .o_boot_osc_mhz(o_boot_osc_mhz), .o_flash_ecc_use(o_flash_ecc_use),
    .o_digital_clk_phase_delay(o_digital_clk_phase_delay));

  ////////////////////////////////////////////////////////////////////////////
  // Bus and flash helpers
  task automatic ahb_xfer(input logic [2:0] idx, input logic wr, input logic [31:0] d,
                          output logic [31:0] rdat);
    i_hsel   <= 1'b1;
    i_haddr  <= {27'h0, idx, 2'h0};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel   <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rdat = o_hrdata;
    `CHK("hresp", HRESP_OKAY, o_hresp)
  endtask : ahb_xfer

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] r;
    ahb_xfer(idx, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    ahb_xfer(idx, 1'b0, 32'h0, r);
    `CHK("hrdata", exp, r)
  endtask : rd

  task automatic apply_reset();
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("port_hold_on", 1'b1, o_port_hold_reset)
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK("port_hold_off", 1'b0, o_port_hold_reset)
  endtask : apply_reset

  task automatic check_cfg(input logic [7:0] c0, c1, c2, c3);
    `CHK("drive_mode", {c2[1:0], c1, c0}, o_port_drive_mode)
    `CHK("ext_reset", c2[7], o_ext_reset_pin_select)
    `CHK("debug_allow", c2[6], o_debug_access_allow)
    `CHK("debug_port", c3[2:1], o_debug_port_select)
    `CHK("debug_en", c2[6] & (c3[2:1] != DPS_OFF), o_debug_enable)
    `CHK("speed_sel", c3[0], o_boot_osc_speed_select)
    `CHK("osc_mhz", c3[0] ? BOOT_FAST_MHZ : BOOT_SLOW_MHZ, o_boot_osc_mhz)
    `CHK("ecc_use", c3[3], o_flash_ecc_use)
    `CHK("phase", c3[7:4], o_digital_clk_phase_delay)
  endtask : check_cfg

  // Check code: data bit i sits at the i-th non-power-of-two position
  function automatic logic [7:0] ecc_of(input logic [63:0] d);
    int         p;
    logic [6:0] s;
    p = 0;
    s = 7'h0;
    for (int i = 0; i < 64; i++) begin
      p++;
      while ((p & (p - 1)) == 0) p++;
      if (d[i]) s ^= p[6:0];
    end
    return {^d ^ ^s, s};
  endfunction : ecc_of

  task automatic fl(input logic [63:0] d, input logic [7:0] e, input logic [63:0] xd,
                    input logic xs, input logic xdb);
    i_flash_valid <= 1'b1;
    i_flash_data  <= d;
    i_flash_ecc   <= e;
    @(posedge i_clk);
    i_flash_valid <= 1'b0;
    @(posedge i_clk);
    `CHK("rvalid", 1'b1, o_flash_rvalid)
    `CHK("flash_data", xd, o_flash_data)
    `CHK("ecc_single", xs, o_ecc_single)
    `CHK("ecc_double", xdb, o_ecc_double)
  endtask : fl

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset     <= 1'b0;
    i_por_reset <= 1'b0;
    @(posedge i_clk);
    check_cfg(8'h00, 8'h00, 8'h40, 8'h0a);
    rd(3'h2, 32'h40);
    rd(3'h3, 32'h0a);
    // Edits land in the latches but not yet at the outputs
    wr(3'h0, 32'hffffffe4);
    wr(3'h1, 32'h0000001b);
    wr(3'h2, 32'h000000ff);
    wr(3'h3, 32'h0000005a);
    wr(3'h6, 32'hffffffff);
    rd(3'h0, 32'he4);
    rd(3'h2, 32'hc3);
    rd(3'h6, 32'h0);
    rd(3'h4, 32'h0a400000);
    check_cfg(8'h00, 8'h00, 8'h40, 8'h0a);
    apply_reset();
    check_cfg(8'he4, 8'h1b, 8'hc3, 8'h5a);
    rd(3'h4, 32'h5ac31be4);
    // Every debug port code, both speeds and both ECC settings
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      b2 = kk[0] ? 8'h82 : 8'h41;
      b3 = {4'(k * 5), kk[0], kk, kk[1]};
      wr(3'h2, {24'h0, b2});
      wr(3'h3, {24'h0, b3});
      apply_reset();
      check_cfg(8'he4, 8'h1b, b2, b3);
    end
    // Flash words: clean, one bit flipped, two bits flipped
    wd = 64'h0123456789abcdef;
    we = ecc_of(wd);
    fl(wd, we, wd, 1'b0, 1'b0);
    fl(wd ^ 64'h20, we, wd, 1'b1, 1'b0);
    fl(wd ^ 64'h220, we, wd ^ 64'h220, 1'b0, 1'b1);
    rd(3'h5, 32'h3);
    wr(3'h5, 32'h1);
    rd(3'h5, 32'h2);
    // With ECC unused a flipped word passes raw and unflagged
    wr(3'h3, 32'h0);
    apply_reset();
    fl(wd ^ 64'h20, we, wd ^ 64'h20, 1'b0, 1'b0);
    // Clock enable low freezes both reset action and flash path
    i_ce          <= 1'b0;
    i_reset       <= 1'b1;
    i_flash_valid <= 1'b1;
    repeat (2) @(posedge i_clk);
    `CHK("ce_hold", 1'b0, o_port_hold_reset)
    `CHK("ce_rvalid", 1'b0, o_flash_rvalid)
    i_reset       <= 1'b0;
    i_flash_valid <= 1'b0;
    i_ce          <= 1'b1;
    @(posedge i_clk);
    report_and_stop();
  end

endmodule : bcl_boot_config_tb

`default_nettype wire
